// file: verilog/tbd_torque_band.sv
`timescale 1ns/1ps
`include "tbd_map.svh"

// Contract
// - Over mode: off, at speed, while running
// - Over action: decelerate, warn, or coast
// - Over threshold 0 to 300 percent
// - Over qualification 0.0 to 10.0 s
// - Low mode: off, at speed, while running
// - Low action: decelerate, warn, or coast
// - Separate low threshold, same reference
// - Over detector watches for rising load
// - Low detector watches for falling load
// - Scalar control: 100 percent rated current
// - Sensorless vector: 100 percent rated torque
// - Over declared after full time above
// - Low declared after full time below
module tbd_torque_band #(
    parameter int unsigned TENTH_CYCLES = `TBD_TENTH_NS / `TBD_CLK_NS
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire tbd_pkg::tbd_drive_t drive,
    input wire logic [`TBD_MEAS_W-1:0] output_current_pct,
    input wire logic [`TBD_MEAS_W-1:0] motor_torque_pct,
    input wire tbd_pkg::tbd_cfg_t over_cfg,
    input wire tbd_pkg::tbd_cfg_t low_cfg,
    input wire logic fault_clear,
    output tbd_pkg::tbd_status_t over_status,
    output tbd_pkg::tbd_status_t low_status,
    output logic decel_stop_req,
    output logic coast_stop_req,
    output logic warn_any
);
    import tbd_pkg::*;

    localparam int unsigned NDET = 2;
    localparam logic [`TBD_PRESC_W-1:0] PRESC_LAST = `TBD_PRESC_W'(TENTH_CYCLES - 1);

    // Arming from mode; the reserved code 3 is treated as off
    function automatic logic armed_by(input tbd_mode_t mode, input tbd_drive_t d);
        logic a;
        a = 1'b0;
        case (mode)
            `TBD_MODE_AT_SPEED: a = d.running & d.freq_reached;
            `TBD_MODE_RUNNING: a = d.running;
            default: a = 1'b0;
        endcase
        return a;
    endfunction

    // Settings beyond the documented range saturate instead of wrapping
    function automatic logic [`TBD_LEVEL_W-1:0] clamp_level(input logic [`TBD_LEVEL_W-1:0] v);
        return (v > `TBD_LEVEL_MAX) ? `TBD_LEVEL_MAX : v;
    endfunction

    function automatic logic [`TBD_TIME_W-1:0] clamp_time(input logic [`TBD_TIME_W-1:0] v);
        return (v > `TBD_TIME_MAX) ? `TBD_TIME_MAX : v;
    endfunction

    // Reference quantity picked by the control method
    wire logic [`TBD_MEAS_W-1:0] meas_pct = drive.sensorless_vector_method ?
        motor_torque_pct :
        output_current_pct;

    wire logic [`TBD_LEVEL_W-1:0] over_thr = clamp_level(over_cfg.level);
    wire logic [`TBD_LEVEL_W-1:0] low_thr = clamp_level(low_cfg.level);

    // Both thresholds are compared against the same selected quantity
    wire logic over_cond = meas_pct > {1'b0, over_thr};
    wire logic low_cond = meas_pct < {1'b0, low_thr};

    wire logic over_armed = armed_by(over_cfg.mode, drive);
    wire logic low_armed = armed_by(low_cfg.mode, drive);

    // Per detector arrays, index 0 is over, index 1 is low
    logic armed [NDET];
    logic cond [NDET];
    tbd_action_t action [NDET];
    logic [`TBD_TIME_W-1:0] qual_time [NDET];

    assign armed[0] = over_armed;
    assign armed[1] = low_armed;
    assign cond[0] = over_cond;
    assign cond[1] = low_cond;
    assign action[0] = over_cfg.action;
    assign action[1] = low_cfg.action;
    assign qual_time[0] = clamp_time(over_cfg.qual_time);
    assign qual_time[1] = clamp_time(low_cfg.qual_time);

    tbd_state_t state [NDET];
    logic [`TBD_PRESC_W-1:0] presc [NDET];
    logic [`TBD_TIME_W-1:0] tenths [NDET];
    tbd_action_t fault_kind [NDET];

    genvar gi;
    generate
        for (gi = 0; gi < NDET; gi++) begin : g_det
            wire logic active = armed[gi] & cond[gi];
            wire logic tick = presc[gi] == PRESC_LAST;
            wire logic qualified = tenths[gi] >= qual_time[gi];
            // Warn is the only action that keeps the drive running
            wire logic is_warn = action[gi] == `TBD_ACT_WARN;
            // Declaration cycle, read only by the frozen stop style; the state decodes the same condition itself
            wire logic declared_now = (state[gi] == TBD_ST_QUAL) & active & qualified;
            tbd_state_t next_state;

            always_comb begin
                next_state = state[gi];
                case (state[gi])
                    TBD_ST_IDLE: begin
                        if (active) begin
                            next_state = TBD_ST_QUAL;
                        end
                    end
                    TBD_ST_QUAL: begin
                        if (!active) begin
                            next_state = TBD_ST_IDLE;
                        end else if (qualified) begin
                            next_state = is_warn ? TBD_ST_WARN : TBD_ST_FAULT;
                        end
                    end
                    TBD_ST_WARN: begin
                        // Warning follows the condition, no latching
                        if (!active) begin
                            next_state = TBD_ST_IDLE;
                        end
                    end
                    TBD_ST_FAULT: begin
                        // Fault holds the stop request until software clears it
                        // A held clear lets a live condition fault again once it requalifies
                        if (fault_clear) begin
                            next_state = TBD_ST_IDLE;
                        end
                    end
                    default: next_state = TBD_ST_IDLE;
                endcase
            end

            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    state[gi] <= TBD_ST_IDLE;
                end else begin
                    state[gi] <= next_state;
                end
            end

            // Time base runs only while qualifying, so the first tenth is a full one
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    presc[gi] <= `TBD_PRESC_RST;
                    tenths[gi] <= `TBD_TENTHS_RST;
                end else if (state[gi] != TBD_ST_QUAL || !active) begin
                    presc[gi] <= `TBD_PRESC_RST;
                    tenths[gi] <= `TBD_TENTHS_RST;
                end else if (tick) begin
                    presc[gi] <= `TBD_PRESC_RST;
                    if (!qualified) begin
                        tenths[gi] <= tenths[gi] + 7'h01;
                    end
                end else begin
                    presc[gi] <= presc[gi] + 22'h000001;
                end
            end

            // Stop style is frozen at the moment the fault is declared
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    fault_kind[gi] <= `TBD_ACT_DECEL;
                end else if (declared_now) begin
                    fault_kind[gi] <= action[gi];
                end
            end
        end
    endgenerate

    wire logic fault0 = state[0] == TBD_ST_FAULT;
    wire logic fault1 = state[1] == TBD_ST_FAULT;
    wire logic warn0 = state[0] == TBD_ST_WARN;
    wire logic warn1 = state[1] == TBD_ST_WARN;

    // Coast only for the explicit coast code; anything else stops by decel
    wire logic coast0 = fault0 & (fault_kind[0] == `TBD_ACT_COAST);
    wire logic coast1 = fault1 & (fault_kind[1] == `TBD_ACT_COAST);
    // Either detector alone is enough to stop the drive
    wire logic any_coast = coast0 | coast1;
    wire logic any_decel = (fault0 & ~coast0) | (fault1 & ~coast1);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            decel_stop_req <= `TBD_STATUS_RST;
            coast_stop_req <= `TBD_STATUS_RST;
            warn_any <= `TBD_STATUS_RST;
        end else begin
            // Coast wins over decel: removing output is the stronger stop
            coast_stop_req <= any_coast;
            decel_stop_req <= any_decel & ~any_coast;
            warn_any <= warn0 | warn1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            over_status <= '0;
            low_status <= '0;
        end else begin
            // Status trails the state by one cycle, like the stop outputs
            over_status.armed <= over_armed;
            over_status.warn <= warn0;
            over_status.fault <= fault0;
            over_status.elapsed <= tenths[0];
            low_status.armed <= low_armed;
            low_status.warn <= warn1;
            low_status.fault <= fault1;
            low_status.elapsed <= tenths[1];
        end
    end

endmodule

// file: verilog/tbd_map.svh
`ifndef TBD_MAP_SVH
`define TBD_MAP_SVH

// Enable mode encodings
`define TBD_MODE_OFF 2'h0
`define TBD_MODE_AT_SPEED 2'h1
`define TBD_MODE_RUNNING 2'h2

// Response action encodings
`define TBD_ACT_DECEL 2'h0
`define TBD_ACT_WARN 2'h1
`define TBD_ACT_COAST 2'h2

// Field widths
`define TBD_LEVEL_W 9
`define TBD_TIME_W 7
`define TBD_MEAS_W 10

// Programmable ranges
`define TBD_LEVEL_MAX 9'h12c
`define TBD_TIME_MAX 7'h64

// Qualification time base: one tenth of a second
`define TBD_TENTH_NS 100000000
`define TBD_CLK_NS 25
`define TBD_PRESC_W 22

// Reset values
`define TBD_STATUS_RST 1'h0
`define TBD_TENTHS_RST 7'h00
`define TBD_PRESC_RST 22'h000000

`endif

// file: verilog/tbd_pkg.sv
`include "tbd_map.svh"

package tbd_pkg;

    typedef logic [1:0] tbd_mode_t;
    typedef logic [1:0] tbd_action_t;

    // Settings of one detector
    typedef struct packed {
        tbd_mode_t mode;
        tbd_action_t action;
        logic [`TBD_LEVEL_W-1:0] level;
        logic [`TBD_TIME_W-1:0] qual_time;
    } tbd_cfg_t;

    // Drive state the detectors are armed from
    typedef struct packed {
        logic running;
        logic freq_reached;
        logic sensorless_vector_method;
    } tbd_drive_t;

    // Per detector indication
    typedef struct packed {
        logic armed;
        logic warn;
        logic fault;
        logic [`TBD_TIME_W-1:0] elapsed;
    } tbd_status_t;

    typedef enum logic [3:0] {
        TBD_ST_IDLE = 4'h1,
        TBD_ST_QUAL = 4'h2,
        TBD_ST_WARN = 4'h4,
        TBD_ST_FAULT = 4'h8
    } tbd_state_t;

endpackage

// file: dv/tbd_drive_model.sv
`timescale 1ns/1ps
module tbd_drive_model (
    input wire logic run,
    input wire logic at_speed,
    input wire logic vector_ctl,
    input wire logic [9:0] load_pct,
    output tbd_pkg::tbd_drive_t drive,
    output logic [9:0] current_pct,
    output logic [9:0] torque_pct
);
    import tbd_pkg::*;
    assign drive = '{run, run & at_speed, vector_ctl};
    // Unselected source shows the inverse so a wrong pick is seen
    assign current_pct = vector_ctl ? ~load_pct : load_pct;
    assign torque_pct = vector_ctl ? load_pct : ~load_pct;
endmodule

// file: dv/tbd_torque_band_properties.sv
`timescale 1ns/1ps
module tbd_torque_band_properties import tbd_pkg::*; #(
    parameter int unsigned TENTH_CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire tbd_drive_t drive,
    input wire logic [9:0] output_current_pct,
    input wire logic [9:0] motor_torque_pct,
    input wire tbd_cfg_t over_cfg,
    input wire tbd_cfg_t low_cfg,
    input wire logic fault_clear,
    input wire tbd_status_t over_status,
    input wire tbd_status_t low_status,
    input wire logic decel_stop_req,
    input wire logic coast_stop_req,
    input wire logic warn_any
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_coast; coast_stop_req |-> over_status.fault || low_status.fault; endproperty
    a_coast: assert property (p_coast) else $error("coast without fault");
    property p_one_stop; !(decel_stop_req && coast_stop_req); endproperty
    a_one_stop: assert property (p_one_stop) else $error("two stop kinds");
    property p_warn; warn_any |-> over_status.warn || low_status.warn; endproperty
    a_warn: assert property (p_warn) else $error("warn without source");
    property p_hold; over_status.fault && !$past(fault_clear) |=> over_status.fault; endproperty
    a_hold: assert property (p_hold) else $error("fault dropped");
    property p_clear; low_status.fault && fault_clear |=> ##1 !low_status.fault; endproperty
    a_clear: assert property (p_clear) else $error("fault not cleared");
    property p_off; (over_cfg.mode == 2'h0) [*2] |=> !over_status.armed; endproperty
    a_off: assert property (p_off) else $error("armed while off");
    property p_run; (over_cfg.mode == 2'h2 && drive.running) [*2] |=> over_status.armed;
    endproperty
    a_run: assert property (p_run) else $error("not armed in run");
    property p_speed; (low_cfg.mode == 2'h1 && !drive.freq_reached) [*2] |=> !low_status.armed;
    endproperty
    a_speed: assert property (p_speed) else $error("armed below speed");
    property p_tmax; over_status.elapsed <= 7'h64; endproperty
    a_tmax: assert property (p_tmax) else $error("elapsed past range");
    c_coast: cover property (coast_stop_req);
    c_decel: cover property (decel_stop_req);
    c_warn: cover property (warn_any);
endmodule
bind tbd_torque_band tbd_torque_band_properties #(.TENTH_CYCLES(TENTH_CYCLES)) u_props (
    .clk_sys(clk_sys), .reset(reset), .drive(drive), .output_current_pct(output_current_pct),
    .motor_torque_pct(motor_torque_pct), .over_cfg(over_cfg), .low_cfg(low_cfg),
    .fault_clear(fault_clear), .over_status(over_status), .low_status(low_status),
    .decel_stop_req(decel_stop_req), .coast_stop_req(coast_stop_req), .warn_any(warn_any));

// file: dv/tbd_torque_band_tb.sv
`timescale 1ns/1ps
module tbd_torque_band_tb;
    import tbd_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic run = 1'b0, at_speed = 1'b0, vec = 1'b0, fault_clear = 1'b0;
    logic [9:0] load = 10'h064;
    logic [9:0] cur, trq;
    tbd_cfg_t over_cfg = '0, low_cfg = '0;
    tbd_drive_t drive;
    tbd_status_t over_status, low_status;
    logic decel_stop_req, coast_stop_req, warn_any;
    int num_errors = 0, total_checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    tbd_drive_model model (.run(run), .at_speed(at_speed), .vector_ctl(vec), .load_pct(load),
        .drive(drive), .current_pct(cur), .torque_pct(trq));
    tbd_torque_band #(.TENTH_CYCLES(4)) DUT (.clk_sys(clk_sys), .reset(reset), .drive(drive),
        .output_current_pct(cur), .motor_torque_pct(trq), .over_cfg(over_cfg),
        .low_cfg(low_cfg), .fault_clear(fault_clear), .over_status(over_status),
        .low_status(low_status), .decel_stop_req(decel_stop_req),
        .coast_stop_req(coast_stop_req), .warn_any(warn_any));
    // Result bits: over fault, low fault, decel, coast, warn
    task automatic step(input int n, input logic [9:0] exp);
        logic [9:0] got;
        repeat (n) @(negedge clk_sys);
        got = {5'h00, over_status.fault, low_status.fault, decel_stop_req, coast_stop_req,
            warn_any};
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_status(input tbd_status_t got, input tbd_status_t exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t status got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Load goes back to 100 percent first, so the over_coast and low_restart_decel faults cannot requalify
    task automatic clear_fault();
        load = 10'h064;
        fault_clear = 1'b1;
        @(negedge clk_sys);
        fault_clear = 1'b0;
    endtask
    task automatic over_coast();
        over_cfg = '{2'h2, 2'h2, 9'h12c, 7'h00};
        run = 1'b1;
        load = 10'h12c;
        step(6, 10'h000);
        check_status(over_status, 10'h200);
        load = 10'h12d;
        step(4, 10'h012);
        check_status(over_status, 10'h280);
        check_status(low_status, 10'h000);
        clear_fault();
        step(3, 10'h000);
        over_cfg = '0;
    endtask
    task automatic over_warn_at_speed();
        over_cfg = '{2'h1, 2'h1, 9'h096, 7'h02};
        load = 10'h0c8;
        step(12, 10'h000);
        check_status(over_status, 10'h000);
        at_speed = 1'b1;
        step(6, 10'h000);
        check_status(over_status, 10'h201);
        step(4, 10'h000);
        step(1, 10'h001);
        step(5, 10'h001);
        check_status(over_status, 10'h300);
        load = 10'h064;
        step(4, 10'h000);
        over_cfg = '0;
    endtask
    task automatic low_restart_decel();
        vec = 1'b1;
        low_cfg = '{2'h2, 2'h0, 9'h032, 7'h03};
        load = 10'h031;
        step(10, 10'h000);
        check_status(low_status, 10'h202);
        load = 10'h032;
        step(2, 10'h000);
        check_status(low_status, 10'h200);
        load = 10'h031;
        step(10, 10'h000);
        check_status(low_status, 10'h202);
        step(8, 10'h00c);
        check_status(low_status, 10'h280);
        clear_fault();
        step(3, 10'h000);
        low_cfg = '0;
    endtask
    // Both detectors fault together, then reserved action and low at-speed arming
    task automatic both_stop();
        over_cfg = '{2'h2, 2'h3, 9'h000, 7'h00};
        low_cfg = '{2'h2, 2'h2, 9'h12c, 7'h00};
        step(4, 10'h01a);
        check_status(low_status, 10'h280);
        low_cfg = '{2'h1, 2'h1, 9'h12c, 7'h00};
        at_speed = 1'b0;
        clear_fault();
        step(4, 10'h014);
        check_status(low_status, 10'h000);
        at_speed = 1'b1;
        step(4, 10'h015);
        check_status(low_status, 10'h300);
        over_cfg = '0;
        low_cfg = '0;
        clear_fault();
        step(3, 10'h000);
    endtask
    task automatic modes_off();
        low_cfg = '{2'h0, 2'h2, 9'h12c, 7'h00};
        over_cfg = '{2'h3, 2'h2, 9'h000, 7'h00};
        step(8, 10'h000);
        check_status(over_status, 10'h000);
        check_status(low_status, 10'h000);
        over_cfg = '{2'h2, 2'h2, 9'h000, 7'h00};
        run = 1'b0;
        step(8, 10'h000);
        check_status(over_status, 10'h000);
    endtask
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        reset = 1'b0;
        step(2, 10'h000);
        over_coast();
        over_warn_at_speed();
        low_restart_decel();
        both_stop();
        modes_off();
        end_of_test();
    end
    // About 120 cycles of tests; a hang is cut well past that, at 3000 cycles
    initial begin
        #(25 * 3000);
        num_errors++;
        end_of_test();
    end
endmodule
